// ===== verilog/fat_pkg.sv
// Constants, types and register map of the frame acquisition trigger block.
// Assumes a single 250 MHz clock and synchronous register strobes.
`default_nettype none
package fat_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TMR_W = 24;
   localparam int CNT_W = 8;
   localparam int NUM_TRIG = 2;
   localparam int NUM_LINES = 4;
   localparam int SRC_W = 3;
   localparam int TRIG_ARM = 0;
   localparam int TRIG_FRM = 1;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] ADDR_ARM_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_FRM_CFG = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_BURST = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_EXPOSURE = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_READOUT = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_SW_TRIG = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1c;

   // Trigger configuration fields.
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_SRC_LSB = 1;
   localparam int CFG_ACT_BIT = 4;
   localparam int CFG_WIDTH_BIT = 5;
   localparam int CFG_W = 6;

   // Software trigger and status fields.
   localparam int SW_ARM_BIT = 0;
   localparam int SW_FRM_BIT = 1;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_EXPOSE_BIT = 2;
   localparam int STAT_READ_BIT = 3;
   localparam int STAT_COUNT_LSB = 8;
   localparam int STAT_LINES_LSB = 16;

   // Reset values.
   localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
   localparam logic [CNT_W-1:0] BURST_RST = 8'h01;
   localparam logic [CNT_W-1:0] BURST_ZERO = 8'h00;
   localparam logic [TMR_W-1:0] EXPOSURE_RST = 24'h00_0064;
   localparam logic [TMR_W-1:0] PERIOD_RST = 24'h00_0800;
   localparam logic [TMR_W-1:0] READOUT_RST = 24'h00_0200;
   localparam logic [TMR_W-1:0] TMR_ZERO = 24'h00_0000;
   localparam logic [TMR_W-1:0] TMR_ONE = 24'h00_0001;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   // Raw line rest levels: CC lines idle high, the general line low.
   localparam logic [NUM_LINES-1:0] LINE_IDLE = 4'he;

   typedef enum logic [SRC_W-1:0] {
      SRC_SOFT = 3'h0,
      SRC_LINE1 = 3'h1,
      SRC_CC1 = 3'h2,
      SRC_CC2 = 3'h3,
      SRC_CC3 = 3'h4
   } fat_src_e;

   // Gray codes along wait-arm, wait-frame, expose, readout.
   typedef enum logic [1:0] {
      ST_WAIT_ARM = 2'h0,
      ST_WAIT_FRAME = 2'h1,
      ST_EXPOSE = 2'h3,
      ST_READOUT = 2'h2
   } fat_state_e;

   // Line index 0 is the general-purpose line, 1..3 the CC lines.
   function automatic logic [1:0] fat_line_idx(input logic [SRC_W-1:0] src);
      fat_line_idx = 2'(src - SRC_LINE1);
   endfunction

   function automatic logic fat_is_hw(input logic [SRC_W-1:0] src);
      fat_is_hw = (src >= SRC_LINE1) && (src <= SRC_CC3);
   endfunction
endpackage
`default_nettype wire

// ===== verilog/fat_edge_if.sv
// Carries trigger source settings to the line edge unit and events back.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface fat_edge_if;
   import fat_pkg::*;
   logic [NUM_TRIG-1:0][SRC_W-1:0] src;
   logic [NUM_TRIG-1:0] fallSel;
   logic [NUM_TRIG-1:0] evtStart;
   logic [NUM_TRIG-1:0] evtEnd;
   logic [NUM_LINES-1:0] lineLvl;
   modport edge_unit (input src, input fallSel, output evtStart,
      output evtEnd, output lineLvl);
   modport ctrl (output src, output fallSel, input evtStart, input evtEnd,
      input lineLvl);
endinterface
`default_nettype wire

// ===== verilog/fat_line_edge.sv
// Synchronises the hardware trigger lines and detects the chosen edges.
// Assumes the lines are slow compared with ref_clk.
`timescale 1ns/100ps
`default_nettype none
module fat_line_edge
   import fat_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Raw lines
   input wire logic gpioLine,
   input wire logic [2:0] ccLine,
   // Control side
   fat_edge_if.edge_unit eif
);
   logic [NUM_LINES-1:0] syncA, syncB;
   logic [NUM_LINES-1:0] next_syncA, next_syncB;
   logic [NUM_TRIG-1:0] prevLvl, next_prevLvl;
   logic [NUM_TRIG-1:0] selLvl;

   always_comb begin
      next_syncA = {ccLine, gpioLine};
      next_syncB = syncA;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Starting at the idle level avoids a false edge after reset.
         syncA <= LINE_IDLE;
         syncB <= LINE_IDLE;
         prevLvl <= '0;
      end else begin
         syncA <= next_syncA;
         syncB <= next_syncB;
         prevLvl <= next_prevLvl;
      end
   end

   // CC lines are negative logic, so their level is inverted.
   assign eif.lineLvl = {~syncB[NUM_LINES-1:1], syncB[0]};

   genvar g;
   generate
      for (g = 0; g < NUM_TRIG; g++) begin : gTrig
         assign selLvl[g] = eif.lineLvl[fat_line_idx(eif.src[g])];
         assign next_prevLvl[g] = selLvl[g];
         // One event per edge; the opposite edge ends a width exposure.
         assign eif.evtStart[g] = eif.fallSel[g] ?
            (prevLvl[g] & ~selLvl[g]) : (~prevLvl[g] & selLvl[g]);
         assign eif.evtEnd[g] = eif.fallSel[g] ?
            (~prevLvl[g] & selLvl[g]) : (prevLvl[g] & ~selLvl[g]);
      end
   endgenerate

   AST_ONE_EDGE: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      $rose(gpioLine) && eif.src[TRIG_FRM] == SRC_LINE1 &&
      !eif.fallSel[TRIG_FRM] |-> ##2 eif.evtStart[TRIG_FRM])
      else $error("rising line edge gave no frame event");
endmodule // fat_line_edge
`default_nettype wire

// ===== verilog/fat_trigger_ctrl.sv
// Arming and frame trigger state machine with exposure and readout timing.
// Assumes synchronous register strobes and slow hardware trigger lines.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Function
// - arming disabled means internal arming events
// - arming enabled starts in wait-arm state (enabling it leaves the machine running until the burst count is reached)
// - frame triggers discarded while waiting to arm
// - arming event moves to wait-frame state
// - burst count reached returns to wait-arm
// - accepted frame trigger starts exposure then readout
// - ready again means back to wait-frame
// - frame trigger disabled uses internal period
// - enabled frame trigger exposes once per trigger
// - frame triggers outside wait-frame are ignored
// - software command counts as one trigger
// - hardware origin is line or CC line
// - configured edge on selected line triggers
// - each trigger keeps its own settings
// - software frames use programmed exposure
// - hardware frames allow timed or width exposure
// - width mode exposes between pulse edges
// - burst length accepts 1 through 255
// - activation selects rising or falling edge
// - CC lines are negative logic
module fat_trigger_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [fat_pkg::ADDR_W-1:0] regAddr,
   input wire logic [fat_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [fat_pkg::DATA_W-1:0] regRdData,
   // Trigger lines
   input wire logic gpioLine,
   input wire logic [2:0] ccLine,
   // Sensor control
   output logic exposing,
   output logic readingOut,
   output logic frameStart
);
   import fat_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   fat_edge_if eif ();

   fat_line_edge uEdge (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .gpioLine(gpioLine),
      .ccLine(ccLine),
      .eif(eif)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [CFG_W-1:0] armCfg, frmCfg, next_armCfg, next_frmCfg;
   logic [CNT_W-1:0] burst, next_burst;
   logic [TMR_W-1:0] expoLen, periodLen, readLen;
   logic [TMR_W-1:0] next_expoLen, next_periodLen, next_readLen;
   logic [DATA_W-1:0] next_regRdData;
   logic wrArm, wrFrm, swArm, swFrm;

   assign wrArm = regWrStrobe && (regAddr == ADDR_ARM_CFG);
   assign wrFrm = regWrStrobe && (regAddr == ADDR_FRM_CFG);
   assign swArm = regWrStrobe && (regAddr == ADDR_SW_TRIG) &&
      regWrData[SW_ARM_BIT];
   assign swFrm = regWrStrobe && (regAddr == ADDR_SW_TRIG) &&
      regWrData[SW_FRM_BIT];

   always_comb begin
      next_armCfg = armCfg;
      next_frmCfg = frmCfg;
      next_burst = burst;
      next_expoLen = expoLen;
      next_periodLen = periodLen;
      next_readLen = readLen;
      if (wrArm) begin
         next_armCfg = regWrData[CFG_W-1:0];
      end
      if (wrFrm) begin
         next_frmCfg = regWrData[CFG_W-1:0];
      end
      // A zero burst length is out of range and is not taken.
      if (regWrStrobe && (regAddr == ADDR_BURST) &&
          (regWrData[CNT_W-1:0] != BURST_ZERO)) begin
         next_burst = regWrData[CNT_W-1:0];
      end
      if (regWrStrobe && (regAddr == ADDR_EXPOSURE)) begin
         next_expoLen = regWrData[TMR_W-1:0];
      end
      if (regWrStrobe && (regAddr == ADDR_PERIOD)) begin
         next_periodLen = regWrData[TMR_W-1:0];
      end
      if (regWrStrobe && (regAddr == ADDR_READOUT)) begin
         next_readLen = regWrData[TMR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         armCfg <= CFG_RST;
         frmCfg <= CFG_RST;
         burst <= BURST_RST;
         expoLen <= EXPOSURE_RST;
         periodLen <= PERIOD_RST;
         readLen <= READOUT_RST;
      end else begin
         armCfg <= next_armCfg;
         frmCfg <= next_frmCfg;
         burst <= next_burst;
         expoLen <= next_expoLen;
         periodLen <= next_periodLen;
         readLen <= next_readLen;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger event selection.
   logic armEn, frmEn, frmHw, widthSel;
   logic armEvt, frmEvt, tick;
   logic [SRC_W-1:0] armSrc, frmSrc;

   assign armEn = armCfg[CFG_EN_BIT];
   assign frmEn = frmCfg[CFG_EN_BIT];
   assign armSrc = armCfg[CFG_SRC_LSB +: SRC_W];
   assign frmSrc = frmCfg[CFG_SRC_LSB +: SRC_W];
   assign frmHw = fat_is_hw(frmSrc);
   assign widthSel = frmEn && frmHw && frmCfg[CFG_WIDTH_BIT];
   // Arming settings sit in slot 0, frame settings in slot 1.
   assign eif.src = {frmSrc, armSrc};
   assign eif.fallSel = {frmCfg[CFG_ACT_BIT], armCfg[CFG_ACT_BIT]};

   always_comb begin
      if (!armEn) begin
         armEvt = 1'b1;
      end else if (fat_is_hw(armSrc)) begin
         armEvt = eif.evtStart[TRIG_ARM];
      end else begin
         armEvt = swArm;
      end
      if (!frmEn) begin
         frmEvt = tick;
      end else if (frmHw) begin
         frmEvt = eif.evtStart[TRIG_FRM];
      end else begin
         frmEvt = swFrm;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Internal frame rate generator, free running while frame trigger is off.
   logic [TMR_W-1:0] periodCnt, next_periodCnt;

   assign tick = !frmEn && (periodCnt == TMR_ZERO);

   always_comb begin
      if (frmEn || (periodCnt == TMR_ZERO)) begin
         next_periodCnt = (periodLen == TMR_ZERO) ? TMR_ZERO :
            periodLen - TMR_ONE;
      end else begin
         next_periodCnt = periodCnt - TMR_ONE;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         periodCnt <= TMR_ZERO;
      end else begin
         periodCnt <= next_periodCnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acquisition state machine.
   fat_state_e state, next_state;
   logic [CNT_W-1:0] frmCount, next_frmCount;
   logic [TMR_W-1:0] timer, next_timer;
   logic expWidth, next_expWidth;
   logic next_exposing, next_readingOut, next_frameStart;
   logic burstDone;

   assign burstDone = armEn && (frmCount == burst);

   always_comb begin
      next_state = state;
      next_frmCount = frmCount;
      next_timer = timer;
      next_expWidth = expWidth;
      next_frameStart = 1'b0;
      case (state)
         ST_WAIT_ARM: begin
            // Frame events here fall through unused.
            next_frmCount = '0;
            if (armEvt) begin
               next_state = ST_WAIT_FRAME;
            end
         end
         ST_WAIT_FRAME: begin
            if (frmEvt) begin
               next_state = ST_EXPOSE;
               next_frameStart = 1'b1;
               // Only frames taken while armed count toward the burst,
               // so an unarmed run cannot leave the count past its end.
               if (armEn) begin
                  next_frmCount = frmCount + CNT_ONE;
               end
               next_expWidth = widthSel;
               next_timer = (expoLen == TMR_ZERO) ? TMR_ZERO :
                  expoLen - TMR_ONE;
            end
         end
         ST_EXPOSE: begin
            if (expWidth ? eif.evtEnd[TRIG_FRM] : (timer == TMR_ZERO)) begin
               next_state = ST_READOUT;
               next_timer = (readLen == TMR_ZERO) ? TMR_ZERO :
                  readLen - TMR_ONE;
            end else if (!expWidth) begin
               next_timer = timer - TMR_ONE;
            end
         end
         ST_READOUT: begin
            if (timer == TMR_ZERO) begin
               if (burstDone) begin
                  next_state = ST_WAIT_ARM;
                  next_frmCount = '0;
               end else begin
                  next_state = ST_WAIT_FRAME;
               end
            end else begin
               next_timer = timer - TMR_ONE;
            end
         end
         default: begin
            next_state = ST_WAIT_ARM;
         end
      endcase
      next_exposing = (next_state == ST_EXPOSE);
      next_readingOut = (next_state == ST_READOUT);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_WAIT_ARM;
         frmCount <= '0;
         timer <= TMR_ZERO;
         expWidth <= 1'b0;
         exposing <= 1'b0;
         readingOut <= 1'b0;
         frameStart <= 1'b0;
      end else begin
         state <= next_state;
         frmCount <= next_frmCount;
         timer <= next_timer;
         expWidth <= next_expWidth;
         exposing <= next_exposing;
         readingOut <= next_readingOut;
         frameStart <= next_frameStart;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port; unmapped and write-only addresses read as zero.
   always_comb begin
      next_regRdData = DATA_ZERO;
      if (regRdStrobe) begin
         case (regAddr)
            ADDR_ARM_CFG: next_regRdData[CFG_W-1:0] = armCfg;
            ADDR_FRM_CFG: next_regRdData[CFG_W-1:0] = frmCfg;
            ADDR_BURST: next_regRdData[CNT_W-1:0] = burst;
            ADDR_EXPOSURE: next_regRdData[TMR_W-1:0] = expoLen;
            ADDR_PERIOD: next_regRdData[TMR_W-1:0] = periodLen;
            ADDR_READOUT: next_regRdData[TMR_W-1:0] = readLen;
            ADDR_STATUS: begin
               next_regRdData[STAT_STATE_LSB +: 2] = state;
               next_regRdData[STAT_EXPOSE_BIT] = exposing;
               next_regRdData[STAT_READ_BIT] = readingOut;
               next_regRdData[STAT_COUNT_LSB +: CNT_W] = frmCount;
               next_regRdData[STAT_LINES_LSB +: NUM_LINES] = eif.lineLvl;
            end
            default: next_regRdData = DATA_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= DATA_ZERO;
      end else begin
         regRdData <= next_regRdData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks. Exposure length is measured by a helper counter.
   logic [TMR_W-1:0] expSeen;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         expSeen <= TMR_ZERO;
      end else begin
         expSeen <= (state == ST_EXPOSE) ? expSeen + TMR_ONE : TMR_ZERO;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   AST_ARM_OFF: assert property (!armEn && state == ST_WAIT_ARM
      |=> state == ST_WAIT_FRAME) else $error("internal arming missing");
   AST_ARM_HOLD: assert property (state == ST_WAIT_ARM && !armEvt
      |=> state == ST_WAIT_ARM && !frameStart)
      else $error("frame started while waiting to arm");
   AST_ARM_TAKE: assert property (state == ST_WAIT_ARM && armEvt
      |=> state == ST_WAIT_FRAME) else $error("arming event lost");
   AST_BURST_END: assert property (state == ST_READOUT &&
      timer == TMR_ZERO && burstDone |=> state == ST_WAIT_ARM &&
      frmCount == '0) else $error("burst end not taken");
   AST_FRAME_GO: assert property (state == ST_WAIT_FRAME && frmEvt
      |=> frameStart && exposing ##1 !frameStart)
      else $error("accepted frame did not start");
   AST_RETURN: assert property (state == ST_READOUT &&
      timer == TMR_ZERO && !burstDone |=> state == ST_WAIT_FRAME)
      else $error("no return to wait-frame");
   AST_IGNORE: assert property (state inside {ST_EXPOSE, ST_READOUT}
      |=> !frameStart && $stable(frmCount) || state == ST_WAIT_ARM)
      else $error("frame trigger taken while busy");
   AST_SOFT: assert property (frmEn && !frmHw && swFrm
      && state == ST_WAIT_FRAME |=> frameStart)
      else $error("software frame trigger lost");
   AST_TIMED: assert property (state == ST_EXPOSE && !expWidth
      && next_state == ST_READOUT |-> expSeen + TMR_ONE ==
      ((expoLen == TMR_ZERO) ? TMR_ONE : expoLen))
      else $error("timed exposure length wrong");
   AST_WIDTH: assert property (state == ST_EXPOSE && expWidth
      && eif.evtEnd[TRIG_FRM] |=> readingOut)
      else $error("width exposure did not end on edge");
   AST_BURST_ZERO: assert property (regWrStrobe &&
      regAddr == ADDR_BURST && regWrData[CNT_W-1:0] == BURST_ZERO
      |=> $stable(burst)) else $error("zero burst accepted");
   AST_SEPARATE: assert property (wrArm |=> $stable(frmCfg))
      else $error("arming write changed frame settings");

   COV_BURST: cover property (state == ST_READOUT ##1 state == ST_WAIT_ARM);
   COV_WIDTH: cover property (expWidth && state == ST_READOUT);
   COV_INTERNAL: cover property (tick && state == ST_WAIT_FRAME);
   COV_IGNORED: cover property (state == ST_WAIT_ARM && swFrm && frmEn);
endmodule // fat_trigger_ctrl
`default_nettype wire

// ===== tb/fat_line_driver.sv
// Model of the frame grabber side that drives the trigger lines.
// Assumes its task is called by the bench right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module fat_line_driver (
   // Clock
   input wire logic ref_clk,
   // Trigger lines
   output logic gpioLine,
   output logic [2:0] ccLine
);
   // The idle level is inactive: low on the line, high on the CC lines.
   initial begin
      gpioLine = 1'b0;
      ccLine = 3'b111;
   end
   /////////////////////////////////////////////////////////////////////
   // Holds line idx active for w cycles and then rests long enough that
   // the device can finish a short frame before the next pulse arrives.
   task automatic pulse(input int idx, input int w);
      if (idx == 0) gpioLine <= 1'b1;
      else ccLine[idx-1] <= 1'b0;
      repeat (w) @(posedge ref_clk);
      gpioLine <= 1'b0;
      ccLine <= 3'b111;
      repeat (16) @(posedge ref_clk);
   endtask
endmodule // fat_line_driver
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the frame acquisition trigger block.
// Assumes the package, the design and the line driver model are compiled.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import fat_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic regWrStrobe = 1'b0;
   logic regRdStrobe = 1'b0;
   logic [DATA_W-1:0] regRdData;
   wire logic gpioLine;
   wire logic [2:0] ccLine;
   logic exposing;
   logic readingOut;
   logic frameStart;
   int miscompares = 0;
   int tests_run = 0;
   int seed = 59709;
   int cyc = 0;
   int nFrames = 0;
   int lastStart = 0;
   int expCnt = 0;
   int rdCnt = 0;
   int hwExp;
   int n0;
   int e0;
   int r0;
   int e;
   int r;
   int t1;
   logic [31:0] d;
   logic [7:0] ra [9] = '{ADDR_ARM_CFG, ADDR_FRM_CFG, ADDR_BURST,
      ADDR_EXPOSURE, ADDR_PERIOD, ADDR_READOUT, ADDR_SW_TRIG, 8'h20, 8'hfc};
   logic [31:0] rv [9] = '{DATA_ZERO, DATA_ZERO, 32'(BURST_RST),
      32'(EXPOSURE_RST), 32'(PERIOD_RST), 32'(READOUT_RST), DATA_ZERO,
      DATA_ZERO, DATA_ZERO};

   fat_trigger_ctrl fat_trigger_ctrl_inst (.ref_clk(ref_clk),
      .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .gpioLine(gpioLine), .ccLine(ccLine),
      .exposing(exposing), .readingOut(readingOut),
      .frameStart(frameStart));
   fat_line_driver fat_line_driver_inst (.ref_clk(ref_clk),
      .gpioLine(gpioLine), .ccLine(ccLine));

   always #2 ref_clk = ~ref_clk;

   // Outputs are sampled at the edge, so each count sees settled values.
   always @(posedge ref_clk) begin
      cyc++;
      if (frameStart === 1'b1) begin
         nFrames++;
         lastStart = cyc;
      end
      if (exposing === 1'b1) expCnt++;
      if (readingOut === 1'b1) rdCnt++;
   end
   /////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A gap cycle after each strobe keeps every assignment one per step.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      regAddr <= a;
      regWrData <= v;
      regWrStrobe <= 1'b1;
      @(posedge ref_clk);
      regWrStrobe <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge ref_clk);
      regRdStrobe <= 1'b0;
      @(posedge ref_clk);
      v = regRdData;
   endtask

   task automatic sw_frame();
      wr(ADDR_SW_TRIG, 32'h2);
      repeat (12) @(posedge ref_clk);
   endtask

   task automatic wait_frames(input int n);
      int m;
      m = nFrames;
      for (int i = 0; i < 4000 && nFrames < m + n; i++) @(posedge ref_clk);
   endtask

   task automatic hw_try(input int s, input int f, input int m, input int w);
      logic [31:0] st;
      int t0;
      wr(ADDR_FRM_CFG, 32'(1 + 2 * s + 16 * f + 32 * m));
      repeat (12) @(posedge ref_clk);
      n0 = nFrames;
      e0 = expCnt;
      t0 = cyc;
      fork
         fat_line_driver_inst.pulse(s - 1, w);
         begin
            repeat (6) @(posedge ref_clk);
            rd(ADDR_STATUS, st);
         end
      join
      check(32'(nFrames - n0), 32'h1);
      check(32'(lastStart - t0 < w), 32'(f == 0));
      check(32'(st[15+s]), 32'h1);
      hwExp = expCnt - e0;
   endtask

   task automatic give_verdict();
      $display("counts: %0d compared, %0d wrong", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   /////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         rd(ra[i], d);
         check(d, rv[i]);
      end
      wr(ADDR_EXPOSURE, 32'h3);
      wr(ADDR_READOUT, 32'h2);
      wr(ADDR_PERIOD, 32'h28);
      wait_frames(3);
      t1 = lastStart;
      wait_frames(1);
      check(32'(lastStart - t1), 32'h28);
      wr(ADDR_FRM_CFG, 32'h1);
      repeat (20) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         e = (i == 0) ? 1 : ($random(seed) & 7) + 1;
         r = (i == 0) ? 1 : ($random(seed) & 7) + 1;
         wr(ADDR_EXPOSURE, 32'(e));
         wr(ADDR_READOUT, 32'(r));
         n0 = nFrames;
         e0 = expCnt;
         r0 = rdCnt;
         wr(ADDR_SW_TRIG, 32'h2);
         wr(ADDR_SW_TRIG, 32'h2);
         repeat (20) @(posedge ref_clk);
         check(32'(nFrames - n0), 32'h1);
         check(32'(expCnt - e0), 32'(e));
         check(32'(rdCnt - r0), 32'(r));
      end
      wr(ADDR_EXPOSURE, 32'h3);
      wr(ADDR_READOUT, 32'h2);
      for (int f = 0; f < 2; f++)
         for (int s = 1; s < 5; s++) hw_try(s, f, 0, 20);
      hw_try(1, 0, 0, 12);
      check(32'(hwExp), 32'h3);
      hw_try(3, 0, 1, 12);
      check(32'(hwExp >= 11 && hwExp <= 13), 32'h1);
      wr(ADDR_FRM_CFG, 32'h1);
      wr(ADDR_BURST, 32'h0);
      rd(ADDR_BURST, d);
      check(d, 32'h1);
      wr(ADDR_BURST, 32'hff);
      rd(ADDR_BURST, d);
      check(d, 32'hff);
      wr(ADDR_BURST, 32'h2);
      wr(ADDR_ARM_CFG, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rd(ADDR_STATUS, d);
         if (d[1:0] != 2'h0) sw_frame();
      end
      rd(ADDR_STATUS, d);
      check(d & 32'hffff, 32'h0);
      n0 = nFrames;
      sw_frame();
      check(32'(nFrames - n0), 32'h0);
      wr(ADDR_SW_TRIG, 32'h1);
      rd(ADDR_STATUS, d);
      check(32'(d[1:0]), 32'(ST_WAIT_FRAME));
      sw_frame();
      rd(ADDR_STATUS, d);
      check(d & 32'hff03, 32'h0101);
      sw_frame();
      rd(ADDR_STATUS, d);
      check(d & 32'hff03, 32'h0);
      check(32'(nFrames - n0), 32'h2);
      wr(ADDR_ARM_CFG, 32'h3);
      rd(ADDR_FRM_CFG, d);
      check(d, 32'h1);
      fat_line_driver_inst.pulse(0, 4);
      rd(ADDR_STATUS, d);
      check(32'(d[1:0]), 32'(ST_WAIT_FRAME));
      sw_frame();
      sw_frame();
      wr(ADDR_ARM_CFG, 32'h0);
      repeat (4) @(posedge ref_clk);
      rd(ADDR_STATUS, d);
      check(32'(d[1:0]), 32'(ST_WAIT_FRAME));
      give_verdict();
   end

   // The full sequence needs well under half of this span.
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
